/* File: core/byte_alu.sv */
// Purpose: APB-controlled byte arithmetic and logic unit with flags and multiplier
// Assumes: pclk at 20 MHz, presetn asynchronous active low, APB slave always ready
// Notes:   A control write of a code up to OP_LAST starts an operation; registers are locked while busy
//
// Chosen here: register access over APB and the register addresses.
`timescale 1ns/10ps
module byte_alu
	import alu_pkg::*;
(
	// Clock and reset
	input  wire logic                              pclk,
	input  wire logic                              presetn,
	// APB slave
	input  wire logic                              psel,
	input  wire logic                              penable,
	input  wire logic                              pwrite,
	input  wire logic [alu_pkg::APB_ADDR_W-1:0]    paddr,
	input  wire logic [alu_pkg::APB_DATA_W-1:0]    pwdata,
	output logic      [alu_pkg::APB_DATA_W-1:0]    prdata,
	output logic                                   pready,
	output logic                                   pslverr
);
	import alu_pkg::*;

	exec_state_t state;
	logic [4:0]  op;
	logic [7:0]  dest;
	logic [7:0]  dest_hi;
	logic [7:0]  src;
	logic [7:0]  imm;
	logic [5:0]  flags;
	logic [15:0] prod;

	logic        mapped;
	logic        wr_acc;
	logic        idle;
	logic        start;
	logic        op_long;
	logic        done;

	logic [7:0]  as_a;
	logic [7:0]  as_b;
	logic        as_cin;
	logic        as_sub;
	logic [7:0]  as_res;
	logic        as_carry;
	logic        as_half;
	logic        as_ovf;

	logic        mul_a_signed;
	logic        mul_b_signed;
	logic [15:0] mul_prod;

	logic [15:0] word_in;
	logic [16:0] word_wide;
	logic [15:0] word_res;

	logic [7:0]  next_dest;
	logic [7:0]  next_dest_hi;
	logic [5:0]  next_flags;
	logic [15:0] next_prod;

	// APB decode
	always_comb
	begin
		case (paddr)
			REG_CTRL, REG_DEST_LO, REG_DEST_HI, REG_SRC,
			REG_IMM, REG_FLAGS, REG_PROD, REG_STATUS: mapped = 1'b1;
			default:                                   mapped = 1'b0;
		endcase
	end

	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~mapped;
	assign wr_acc  = psel & penable & pwrite & mapped;
	assign idle    = (state == ST_IDLE);
	assign start   = wr_acc & idle & (paddr == REG_CTRL) & (pwdata[4:0] <= OP_LAST);

	// Word and multiply operations run for two cycles, all others one
	always_comb
	begin
		case (op)
			OP_WORD_SUM, OP_WORD_DIFF, OP_PROD_U, OP_PROD_S, OP_PROD_M: op_long = 1'b1;
			default:                                                    op_long = 1'b0;
		endcase
	end

	assign done = ((state == ST_CYCLE1) & ~op_long) | (state == ST_CYCLE2);

	// Execution sequencer
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			state <= ST_IDLE;
		else
		begin
			case (state)
				ST_IDLE:   if (start) state <= ST_CYCLE1;
				ST_CYCLE1: state <= op_long ? ST_CYCLE2 : ST_IDLE;
				ST_CYCLE2: state <= ST_IDLE;
				default:   state <= ST_IDLE;
			endcase
		end
	end

	// Operation code latch
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			op <= OP_SUM;
		else if (start)
			op <= pwdata[4:0];
	end

	// Adder operand steering
	always_comb
	begin
		as_a   = dest;
		as_b   = src;
		as_cin = 1'b0;
		as_sub = 1'b0;
		case (op)
			OP_SUM_CARRY:    as_cin = flags[FLAG_C];
			OP_DIFF:         as_sub = 1'b1;
			OP_DIFF_IMM:
			begin
				as_b   = imm;
				as_sub = 1'b1;
			end
			OP_DIFF_BORROW:
			begin
				as_cin = flags[FLAG_C];
				as_sub = 1'b1;
			end
			OP_DIFF_BRW_IMM:
			begin
				as_b   = imm;
				as_cin = flags[FLAG_C];
				as_sub = 1'b1;
			end
			OP_ARITH_INVERT:
			begin
				as_a   = ZERO_BYTE;
				as_b   = dest;
				as_sub = 1'b1;
			end
			OP_STEP_UP:      as_b = ONE_BYTE;
			OP_STEP_DOWN:
			begin
				as_b   = ONE_BYTE;
				as_sub = 1'b1;
			end
			default:         as_sub = 1'b0;
		endcase
	end

	byte_addsub u_addsub
	(
		.a     (as_a),
		.b     (as_b),
		.cin   (as_cin),
		.sub   (as_sub),
		.res   (as_res),
		.carry (as_carry),
		.half  (as_half),
		.ovf   (as_ovf)
	);

	// Multiplier signedness
	assign mul_a_signed = (op == OP_PROD_S) | (op == OP_PROD_M);
	assign mul_b_signed = (op == OP_PROD_S);

	byte_multiplier u_mult
	(
		.a        (dest),
		.b        (src),
		.a_signed (mul_a_signed),
		.b_signed (mul_b_signed),
		.prod     (mul_prod)
	);

	// Word pair arithmetic with a 6-bit immediate
	assign word_in   = {dest_hi, dest};
	assign word_wide = (op == OP_WORD_DIFF)
	                 ? ({1'b0, word_in} - {11'h000, imm[WORD_IMM_W-1:0]})
	                 : ({1'b0, word_in} + {11'h000, imm[WORD_IMM_W-1:0]});
	assign word_res  = word_wide[15:0];

	// Result and flag selection
	always_comb
	begin
		next_dest    = dest;
		next_dest_hi = dest_hi;
		next_flags   = flags;
		next_prod    = prod;
		case (op)
			OP_SUM, OP_SUM_CARRY, OP_DIFF, OP_DIFF_IMM,
			OP_DIFF_BORROW, OP_DIFF_BRW_IMM, OP_ARITH_INVERT:
			begin
				next_dest          = as_res;
				next_flags[FLAG_C] = as_carry;
				next_flags[FLAG_H] = as_half;
				next_flags[FLAG_N] = as_res[7];
				next_flags[FLAG_V] = as_ovf;
				next_flags[FLAG_S] = as_res[7] ^ as_ovf;
				if (op == OP_DIFF_BORROW || op == OP_DIFF_BRW_IMM)
					next_flags[FLAG_Z] = (as_res == ZERO_BYTE) & flags[FLAG_Z];
				else
					next_flags[FLAG_Z] = (as_res == ZERO_BYTE);
			end
			OP_STEP_UP, OP_STEP_DOWN:
			begin
				next_dest          = as_res;
				next_flags[FLAG_Z] = (as_res == ZERO_BYTE);
				next_flags[FLAG_N] = as_res[7];
				next_flags[FLAG_V] = as_ovf;
				next_flags[FLAG_S] = as_res[7] ^ as_ovf;
			end
			OP_CONJ, OP_CONJ_IMM, OP_DISJ, OP_DISJ_IMM, OP_XOR,
			OP_SET_MASK, OP_CLEAR_MASK, OP_PROBE, OP_WIPE:
			begin
				case (op)
					OP_CONJ:       next_dest = dest & src;
					OP_CONJ_IMM:   next_dest = dest & imm;
					OP_DISJ:       next_dest = dest | src;
					OP_DISJ_IMM:   next_dest = dest | imm;
					OP_XOR:        next_dest = dest ^ src;
					OP_SET_MASK:   next_dest = dest | imm;
					OP_CLEAR_MASK: next_dest = dest & (ALL_ONES - imm);
					OP_PROBE:      next_dest = dest & dest;
					OP_WIPE:       next_dest = dest ^ dest;
					default:       next_dest = dest;
				endcase
				next_flags[FLAG_Z] = (next_dest == ZERO_BYTE);
				next_flags[FLAG_N] = next_dest[7];
				next_flags[FLAG_V] = 1'b0;
				next_flags[FLAG_S] = next_dest[7];
			end
			OP_BIT_INVERT:
			begin
				next_dest          = ALL_ONES - dest;
				next_flags[FLAG_Z] = (next_dest == ZERO_BYTE);
				next_flags[FLAG_C] = 1'b1;
				next_flags[FLAG_N] = next_dest[7];
				next_flags[FLAG_V] = 1'b0;
				next_flags[FLAG_S] = next_dest[7];
			end
			OP_FILL:         next_dest = ALL_ONES;
			OP_WORD_SUM, OP_WORD_DIFF:
			begin
				next_dest          = word_res[7:0];
				next_dest_hi       = word_res[15:8];
				next_flags[FLAG_Z] = (word_res == PROD_RESET);
				next_flags[FLAG_N] = word_res[15];
				if (op == OP_WORD_SUM)
				begin
					next_flags[FLAG_V] = ~dest_hi[7] & word_res[15];
					next_flags[FLAG_C] = dest_hi[7] & ~word_res[15];
					next_flags[FLAG_S] = word_res[15] ^ (~dest_hi[7] & word_res[15]);
				end
				else
				begin
					next_flags[FLAG_V] = dest_hi[7] & ~word_res[15];
					next_flags[FLAG_C] = word_res[15] & ~dest_hi[7];
					next_flags[FLAG_S] = word_res[15] ^ (dest_hi[7] & ~word_res[15]);
				end
			end
			OP_PROD_U, OP_PROD_S, OP_PROD_M:
			begin
				next_prod          = mul_prod;
				next_flags[FLAG_Z] = (mul_prod == PROD_RESET);
				next_flags[FLAG_C] = mul_prod[15];
			end
			default:         next_dest = dest;
		endcase
	end

	// Destination byte
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			dest <= BYTE_RESET;
		else if (done)
			dest <= next_dest;
		else if (wr_acc && idle && paddr == REG_DEST_LO)
			dest <= pwdata[7:0];
	end

	// Destination high byte of the word pair
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			dest_hi <= BYTE_RESET;
		else if (done)
			dest_hi <= next_dest_hi;
		else if (wr_acc && idle && paddr == REG_DEST_HI)
			dest_hi <= pwdata[7:0];
	end

	// Source and immediate operands
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			src <= BYTE_RESET;
			imm <= BYTE_RESET;
		end
		else if (wr_acc && idle)
		begin
			if (paddr == REG_SRC)
				src <= pwdata[7:0];
			if (paddr == REG_IMM)
				imm <= pwdata[7:0];
		end
	end

	// Status flags
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			flags <= FLAGS_RESET;
		else if (done)
			flags <= next_flags;
		else if (wr_acc && idle && paddr == REG_FLAGS)
			flags <= pwdata[FLAG_W-1:0];
	end

	// Product pair
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prod <= PROD_RESET;
		else if (done)
			prod <= next_prod;
	end

	// Read data, captured in the setup phase
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= '0;
		else if (psel && !penable && !pwrite)
		begin
			case (paddr)
				REG_CTRL:    prdata <= {27'h0000000, op};
				REG_DEST_LO: prdata <= {24'h000000, dest};
				REG_DEST_HI: prdata <= {24'h000000, dest_hi};
				REG_SRC:     prdata <= {24'h000000, src};
				REG_IMM:     prdata <= {24'h000000, imm};
				REG_FLAGS:   prdata <= {26'h0000000, flags};
				REG_PROD:    prdata <= {16'h0000, prod};
				REG_STATUS:  prdata <= {31'h00000000, ~idle};
				default:     prdata <= '0;
			endcase
		end
	end

endmodule

/* File: core/alu_pkg.sv */
// Purpose: Shared constants for the byte arithmetic and logic unit
// Assumes: APB register map with one aligned 32-bit word per register
// Notes:   Operation codes are the values software writes to the control register
package alu_pkg;

	// Bus geometry
	localparam int          APB_ADDR_W      = 8;
	localparam int          APB_DATA_W      = 32;

	// Register byte addresses
	localparam logic [7:0]  REG_CTRL        = 8'h00;
	localparam logic [7:0]  REG_DEST_LO     = 8'h04;
	localparam logic [7:0]  REG_DEST_HI     = 8'h08;
	localparam logic [7:0]  REG_SRC         = 8'h0C;
	localparam logic [7:0]  REG_IMM         = 8'h10;
	localparam logic [7:0]  REG_FLAGS       = 8'h14;
	localparam logic [7:0]  REG_PROD        = 8'h18;
	localparam logic [7:0]  REG_STATUS      = 8'h1C;

	// Flag register field positions
	localparam int          FLAG_C          = 0;
	localparam int          FLAG_Z          = 1;
	localparam int          FLAG_N          = 2;
	localparam int          FLAG_V          = 3;
	localparam int          FLAG_S          = 4;
	localparam int          FLAG_H          = 5;
	localparam int          FLAG_W          = 6;
	localparam int          STATUS_BUSY     = 0;

	// Reset values and fixed byte values
	localparam logic [7:0]  BYTE_RESET      = 8'h00;
	localparam logic [5:0]  FLAGS_RESET     = 6'h00;
	localparam logic [15:0] PROD_RESET      = 16'h0000;
	localparam logic [7:0]  ALL_ONES        = 8'hFF;
	localparam logic [7:0]  ZERO_BYTE       = 8'h00;
	localparam logic [7:0]  ONE_BYTE        = 8'h01;
	localparam int          WORD_IMM_W      = 6;

	// Execution lengths in clock cycles
	localparam int          SHORT_CYCLES    = 1;
	localparam int          LONG_CYCLES     = 2;

	// Operation codes
	localparam logic [4:0]  OP_SUM          = 5'h00;
	localparam logic [4:0]  OP_SUM_CARRY    = 5'h01;
	localparam logic [4:0]  OP_WORD_SUM     = 5'h02;
	localparam logic [4:0]  OP_DIFF         = 5'h03;
	localparam logic [4:0]  OP_DIFF_IMM     = 5'h04;
	localparam logic [4:0]  OP_DIFF_BORROW  = 5'h05;
	localparam logic [4:0]  OP_DIFF_BRW_IMM = 5'h06;
	localparam logic [4:0]  OP_WORD_DIFF    = 5'h07;
	localparam logic [4:0]  OP_CONJ         = 5'h08;
	localparam logic [4:0]  OP_CONJ_IMM     = 5'h09;
	localparam logic [4:0]  OP_DISJ         = 5'h0A;
	localparam logic [4:0]  OP_DISJ_IMM     = 5'h0B;
	localparam logic [4:0]  OP_XOR          = 5'h0C;
	localparam logic [4:0]  OP_BIT_INVERT   = 5'h0D;
	localparam logic [4:0]  OP_ARITH_INVERT = 5'h0E;
	localparam logic [4:0]  OP_SET_MASK     = 5'h0F;
	localparam logic [4:0]  OP_CLEAR_MASK   = 5'h10;
	localparam logic [4:0]  OP_STEP_UP      = 5'h11;
	localparam logic [4:0]  OP_STEP_DOWN    = 5'h12;
	localparam logic [4:0]  OP_PROBE        = 5'h13;
	localparam logic [4:0]  OP_WIPE         = 5'h14;
	localparam logic [4:0]  OP_FILL         = 5'h15;
	localparam logic [4:0]  OP_PROD_U       = 5'h16;
	localparam logic [4:0]  OP_PROD_S       = 5'h17;
	localparam logic [4:0]  OP_PROD_M       = 5'h18;
	localparam logic [4:0]  OP_LAST         = 5'h18;

	typedef enum logic [1:0] {ST_IDLE, ST_CYCLE1, ST_CYCLE2} exec_state_t;

endpackage

/* File: core/byte_addsub.sv */
// Purpose: 8-bit adder/subtractor with carry, half-carry and overflow
// Assumes: Carry input is added on sum, subtracted as borrow on difference
// Notes:   Carry output is the borrow when subtracting
`timescale 1ns/10ps
module byte_addsub
(
	// Operands
	input  wire logic [7:0] a,
	input  wire logic [7:0] b,
	input  wire logic       cin,
	input  wire logic       sub,
	// Result and flags
	output logic      [7:0] res,
	output logic            carry,
	output logic            half,
	output logic            ovf
);
	logic [8:0] wide;

	always_comb
	begin
		if (sub)
			wide = {1'b0, a} - {1'b0, b} - {8'h00, cin};
		else
			wide = {1'b0, a} + {1'b0, b} + {8'h00, cin};
	end

	assign res   = wide[7:0];
	assign carry = wide[8];
	assign half  = sub ? ((~a[3] & b[3]) | (b[3] & res[3]) | (res[3] & ~a[3]))
	                   : ((a[3] & b[3]) | (b[3] & ~res[3]) | (~res[3] & a[3]));
	assign ovf   = sub ? ((a[7] & ~b[7] & ~res[7]) | (~a[7] & b[7] & res[7]))
	                   : ((a[7] & b[7] & ~res[7]) | (~a[7] & ~b[7] & res[7]));
endmodule

/* File: core/byte_multiplier.sv */
// Purpose: 8x8 multiplier with per-operand signedness
// Assumes: Operands are held stable while the product is taken
// Notes:   Each operand is sign-extended by one bit when marked signed
`timescale 1ns/10ps
module byte_multiplier
(
	// Operands
	input  wire logic [7:0]  a,
	input  wire logic [7:0]  b,
	input  wire logic        a_signed,
	input  wire logic        b_signed,
	// Product
	output logic      [15:0] prod
);
	logic signed [8:0]  a_ext;
	logic signed [8:0]  b_ext;
	logic signed [17:0] full;

	assign a_ext = $signed({a_signed & a[7], a});
	assign b_ext = $signed({b_signed & b[7], b});
	assign full  = a_ext * b_ext;
	assign prod  = full[15:0];
endmodule

/* File: sim/byte_alu_assertions.sv */
// Purpose: Bus-side checks for the byte arithmetic and logic unit
// Assumes: Master leaves one idle cycle between transfers
// Notes:   Busy is only visible through reads of the status register
`timescale 1ns/10ps
module byte_alu_checker
	import alu_pkg::*;
(
	// Clock and reset
	input  wire logic                           pclk,
	input  wire logic                           presetn,
	// APB
	input  wire logic                           psel,
	input  wire logic                           penable,
	input  wire logic                           pwrite,
	input  wire logic [alu_pkg::APB_ADDR_W-1:0] paddr,
	input  wire logic [alu_pkg::APB_DATA_W-1:0] pwdata,
	input  wire logic [alu_pkg::APB_DATA_W-1:0] prdata,
	input  wire logic                           pready,
	input  wire logic                           pslverr
);
	logic acc;
	logic unm;
	logic lng;
	assign acc = psel & penable;
	assign unm = (paddr[1:0] != 2'h0) || (paddr > REG_STATUS);
	assign lng = pwdata[4:0] inside {OP_WORD_SUM, OP_WORD_DIFF, OP_PROD_U, OP_PROD_S, OP_PROD_M};

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence ctrl_wr;
		acc && pwrite && paddr == REG_CTRL && pwdata[4:0] <= OP_LAST;
	endsequence
	sequence stat_rd;
		psel && !penable && !pwrite && paddr == REG_STATUS ##1 acc;
	endsequence

	ready_high_a: assert property (acc |-> pready) else $error("pready low in access");
	err_unmapped_a: assert property (acc && unm |-> pslverr) else $error("no error on hole");
	err_clear_a: assert property (!(acc && unm) |-> !pslverr) else $error("stray pslverr");
	rd_hold_a: assert property (acc && !pwrite |=> $stable(prdata)) else $error("read data moved");
	hole_zero_a: assert property (acc && !pwrite && unm |-> prdata == 32'h0)
		else $error("hole read not zero");
	byte_upper_a: assert property (acc && !pwrite && !unm && paddr != REG_PROD
		|-> prdata[31:8] == 24'h0) else $error("upper read bits set");
	prod_upper_a: assert property (acc && !pwrite && paddr == REG_PROD
		|-> prdata[31:16] == 16'h0) else $error("product upper bits set");
	long_busy_a: assert property ((ctrl_wr ##0 lng) ##2 stat_rd |-> prdata[0])
		else $error("two-cycle op not busy");
	long_done_a: assert property ((ctrl_wr ##0 lng) ##2 stat_rd ##2 stat_rd
		|-> !prdata[0]) else $error("two-cycle op too long");
	short_done_a: assert property ((ctrl_wr ##0 !lng) ##2 stat_rd |-> !prdata[0])
		else $error("one-cycle op too long");
endmodule

bind byte_alu byte_alu_checker u_byte_alu_checker (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr));

/* File: sim/byte_alu_tb.sv */
// Purpose: Self-checking bench for the byte arithmetic and logic unit
// Assumes: Zero-wait APB slave, one idle cycle between transfers
// Notes:   Vector: hi, lo, src, imm, flags in, result, flag mask, flags out
`timescale 1ns/10ps
module byte_alu_tb;
	import alu_pkg::*;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	wire  [31:0] prdata;
	wire         pready;
	wire         pslverr;
	logic [31:0] rdat;
	logic        rerr;
	int          err_total = 0;
	int          checks = 0;

	byte_alu u_byte_alu (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr));

	always #25 pclk = ~pclk;

	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Only the watchdog ends a wait for pready
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task chk(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e)
		begin
			err_total++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task run(input logic [4:0] o, input logic [71:0] v);
		logic [31:0] got;
		int          n;
		logic [31:0] exp_polls;
		xfer(1'b1, REG_DEST_HI, {24'h0, v[71:64]});
		xfer(1'b1, REG_DEST_LO, {24'h0, v[63:56]});
		xfer(1'b1, REG_SRC, {24'h0, v[55:48]});
		xfer(1'b1, REG_IMM, {24'h0, v[47:40]});
		xfer(1'b1, REG_FLAGS, {24'h0, v[39:32]});
		xfer(1'b1, REG_CTRL, {27'h0, o});
		n = 0;
		do
		begin
			xfer(1'b0, REG_STATUS, 32'h0);
			n++;
		end
		while (rdat[0] !== 1'b0 && n < 8);
		// Two-cycle ops are still busy at the first poll, one-cycle ops are not
		exp_polls = 32'h1;
		if (o inside {OP_WORD_SUM, OP_WORD_DIFF, OP_PROD_U, OP_PROD_S, OP_PROD_M})
			exp_polls = 32'h2;
		chk(32'(n), exp_polls);
		if (o >= OP_PROD_U)
		begin
			xfer(1'b0, REG_PROD, 32'h0);
			got = rdat;
		end
		else
		begin
			xfer(1'b0, REG_DEST_HI, 32'h0);
			got = {16'h0, rdat[7:0], 8'h00};
			xfer(1'b0, REG_DEST_LO, 32'h0);
			got[7:0] = rdat[7:0];
		end
		chk(got, {16'h0, v[31:16]});
		xfer(1'b0, REG_FLAGS, 32'h0);
		chk(rdat & {24'h0, v[15:8]}, {24'h0, v[7:0]});
	endtask

	task wrap_up;
		$display("checks=%0d err_total=%0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	initial
	begin
		repeat (20000) @(posedge pclk);
		err_total++;
		wrap_up();
	end

	initial
	begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		for (int a = 0; a < 32; a += 4)
		begin
			xfer(1'b0, 8'(a), 32'h0);
			chk(rdat, 32'h0);
		end
		$display("test reset done");
		run(OP_SUM, 72'h00_7F_01_00_00_0080_3F_2C);
		run(OP_SUM_CARRY, 72'h00_FF_00_00_01_0000_3F_23);
		run(OP_WORD_SUM, 72'h7F_FF_00_41_00_8000_1F_0C);
		run(OP_DIFF, 72'h00_00_01_00_00_00FF_3F_35);
		run(OP_DIFF_IMM, 72'h00_80_00_01_00_007F_3F_38);
		run(OP_DIFF_BORROW, 72'h00_05_04_00_01_0000_3F_00);
		run(OP_DIFF_BRW_IMM, 72'h00_10_00_0F_03_0000_3F_22);
		run(OP_WORD_DIFF, 72'h00_00_00_01_00_FFFF_1F_15);
		run(OP_CONJ, 72'h00_F0_8F_00_21_0080_3F_35);
		run(OP_CONJ_IMM, 72'h00_55_00_AA_08_0000_3F_02);
		run(OP_DISJ, 72'h00_01_80_00_00_0081_1E_14);
		run(OP_DISJ_IMM, 72'h00_00_00_00_00_0000_1E_02);
		run(OP_XOR, 72'h00_AA_AB_00_00_0001_1E_00);
		run(OP_BIT_INVERT, 72'h00_0F_00_00_00_00F0_1F_15);
		run(OP_ARITH_INVERT, 72'h00_80_00_00_00_0080_3F_0D);
		run(OP_SET_MASK, 72'h00_01_00_80_00_0081_1E_14);
		run(OP_CLEAR_MASK, 72'h00_FF_00_0F_00_00F0_1E_14);
		run(OP_STEP_UP, 72'h00_7F_00_00_01_0080_1F_0D);
		run(OP_STEP_DOWN, 72'h00_80_00_00_00_007F_1E_18);
		run(OP_PROBE, 72'h00_9C_00_00_00_009C_1E_14);
		run(OP_WIPE, 72'h00_5A_00_00_00_0000_1E_02);
		run(OP_FILL, 72'h00_12_00_00_2A_00FF_3F_2A);
		run(OP_PROD_U, 72'h00_FF_FF_00_00_FE01_03_01);
		run(OP_PROD_S, 72'h00_FF_FF_00_00_0001_03_00);
		run(OP_PROD_M, 72'h00_FF_02_00_00_FFFE_03_01);
		run(OP_PROD_U, 72'h00_00_37_00_00_0000_03_02);
		$display("test operations done");
		xfer(1'b1, REG_PROD, 32'h0000_1234);
		xfer(1'b0, REG_PROD, 32'h0);
		chk(rdat, 32'h0);
		xfer(1'b1, REG_CTRL, 32'h0000_001F);
		xfer(1'b0, REG_CTRL, 32'h0);
		chk(rdat, {27'h0, OP_PROD_U});
		xfer(1'b1, 8'h20, 32'hFFFF_FFFF);
		chk({31'h0, rerr}, 32'h1);
		xfer(1'b0, 8'h20, 32'h0);
		chk({rdat[30:0], rerr}, 32'h1);
		xfer(1'b1, REG_SRC, 32'hFFFF_FFFF);
		xfer(1'b0, REG_SRC, 32'h0);
		chk(rdat, 32'h0000_00FF);
		// Reset in mid-run clears the operand registers
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		xfer(1'b0, REG_SRC, 32'h0);
		chk(rdat, 32'h0);
		$display("test map done");
		wrap_up();
	end
endmodule
